// ==== include/stc_cfg.svh ====
// Address map, field positions and reset values of the transmit lane block.
`ifndef STC_CFG_SVH
`define STC_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define STC_DEC_MSB      11
`define STC_CFG_OFFSET   12'h000
`define STC_STAT_OFFSET  12'h004

// ****************************************************************
// Configuration register fields
// ****************************************************************
`define STC_FTP_BIT      16
`define STC_DE_MSB       15
`define STC_DE_LSB       12
`define STC_SWING_MSB    11
`define STC_SWING_LSB    9
`define STC_CM_BIT       8
`define STC_INV_BIT      7
`define STC_RATE_MSB     6
`define STC_RATE_LSB     5
`define STC_WIDTH_MSB    4
`define STC_WIDTH_LSB    2
`define STC_EN_BIT       0
`define STC_CFG_WMASK    32'h0001_ffff
`define STC_CFG_RESET    32'h0000_0000

// ****************************************************************
// Status register fields
// ****************************************************************
`define STC_ST_ACTIVE    0
`define STC_ST_REDUCED   1
`define STC_ST_POS       2

// ****************************************************************
// Bus encodings and divider limits
// ****************************************************************
`define STC_HSIZE_WORD   3'h2
`define STC_DIV_FULL     2'h0
`define STC_DIV_HALF     2'h1
`define STC_DIV_QUARTER  2'h3

`endif

// ==== include/stc_lane_if.sv ====
// Carrier between the register slave and the lane output stage.
interface stc_lane_if;
  import stc_pkg::*;

  logic [3:0]   deemph;
  logic         invert;
  stc_rate_type rate;
  logic         enable;
  logic         pos;
  logic         neg;
  logic         reduced;
  logic         taken;

  modport ctrl (output deemph, output invert, output rate, output enable,
                input pos, input neg, input reduced, input taken);
  modport lane (input deemph, input invert, input rate, input enable,
                output pos, output neg, output reduced, output taken);
endinterface

// ==== include/stc_pkg.sv ====
// Types shared by the transmit lane configuration block.
package stc_pkg;

  // Line rate relative to the PLL rate.
  typedef enum logic [1:0] {
    STC_RATE_FULL    = 2'h0,
    STC_RATE_HALF    = 2'h1,
    STC_RATE_QUARTER = 2'h2,
    STC_RATE_RSVD    = 2'h3
  } stc_rate_type;

endpackage

// ==== rtl/stc_lane_drive.sv ====
// Lane output stage: rate divider, polarity and de-emphasis marking.
`include "stc_cfg.svh"

module stc_lane_drive
  import stc_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic tx_serial_data,
  stc_lane_if.lane  lane
);

  logic [1:0] div_r;
  logic [1:0] div_nxt;
  logic [1:0] limit;
  logic       strobe;
  logic       prev_r;
  logic       prev_nxt;
  logic       pos_r;
  logic       pos_nxt;
  logic       neg_r;
  logic       neg_nxt;
  logic       red_r;
  logic       red_nxt;
  logic       taken_r;

  // ****************************************************************
  // Bit pacing and pair drive
  // ****************************************************************

  // The divider sets how many clocks each line bit lasts; the reserved
  // rate code falls back to full rate so the lane never stalls.
  always_comb begin
    unique case (lane.rate)
      STC_RATE_HALF:    limit = `STC_DIV_HALF;    // R9
      STC_RATE_QUARTER: limit = `STC_DIV_QUARTER; // R9
      default:          limit = `STC_DIV_FULL;    // R9
    endcase
    strobe   = lane.enable && (div_r >= limit);
    div_nxt  = (!lane.enable || strobe) ? 2'h0 : div_r + 2'h1;
    prev_nxt = prev_r;
    pos_nxt  = 1'b0;
    neg_nxt  = 1'b0;
    red_nxt  = 1'b0;
    if (strobe) begin
      prev_nxt = tx_serial_data;
      pos_nxt  = tx_serial_data ^ lane.invert;  // R8
      neg_nxt  = ~(tx_serial_data ^ lane.invert);  // R8
      // With a nonzero de-emphasis code, a bit with no transition before it is sent at reduced level.
      red_nxt  = (lane.deemph != 4'h0) && (tx_serial_data == prev_r); // R4
    end else if (lane.enable) begin
      pos_nxt  = pos_r;
      neg_nxt  = neg_r;
      red_nxt  = red_r;
    end
  end

  // Both legs rest low while the transmitter is off.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r   <= 2'h0;
      prev_r  <= 1'b0;
      pos_r   <= 1'b0;
      neg_r   <= 1'b0;
      red_r   <= 1'b0;
      taken_r <= 1'b0;
    end else begin
      div_r   <= div_nxt;
      prev_r  <= prev_nxt;
      pos_r   <= pos_nxt;
      neg_r   <= neg_nxt;
      red_r   <= red_nxt;
      taken_r <= strobe;
    end
  end

  assign lane.pos     = pos_r;
  assign lane.neg     = neg_r;
  assign lane.reduced = red_r;
  assign lane.taken   = taken_r;

  // ****************************************************************
  // Checks
  // ****************************************************************

  // Cycles since the last bit and since the rate setting last moved.
  logic [3:0] gap_r;
  logic [3:0] calm_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_r  <= 4'h0;
      calm_r <= 4'h0;
    end else begin
      gap_r  <= taken_r ? 4'h0 : ((gap_r == 4'hf) ? gap_r : gap_r + 4'h1);
      calm_r <= ($changed(lane.rate) || !lane.enable) ? 4'h0 :
                ((calm_r == 4'hf) ? calm_r : calm_r + 4'h1);
    end
  end

  a_pair_polarity: assert property ( // R8
    @(posedge hclk) disable iff (!hresetn)
    strobe |=> (pos_r != neg_r) &&
               (pos_r == ($past(tx_serial_data) ^ $past(lane.invert))))
    else $error("pair polarity does not follow data and invert");
  a_deemph_mark: assert property ( // R4
    @(posedge hclk) disable iff (!hresetn)
    strobe && (lane.deemph == 4'h0) |=> !red_r)
    else $error("reduced level marked with de-emphasis off");
  a_deemph_repeat: assert property ( // R4
    @(posedge hclk) disable iff (!hresetn)
    strobe && taken_r && (lane.deemph != 4'h0) && $stable(lane.invert)
      |=> red_r == ($past(pos_r) == pos_r))
    else $error("reduced level does not match missing transition");
  // The calm counter lags a rate change by one edge, so the rate must
  // also be stable here or an old-rate bit would be judged by the new.
  a_rate_quarter: assert property ( // R9
    @(posedge hclk) disable iff (!hresetn)
    taken_r && (calm_r > 4'h5) && (lane.rate == STC_RATE_QUARTER)
      && $stable(lane.rate) |-> gap_r == 4'h3)
    else $error("quarter rate bit spacing wrong");
  a_rate_half: assert property ( // R9
    @(posedge hclk) disable iff (!hresetn)
    taken_r && (calm_r > 4'h3) && (lane.rate == STC_RATE_HALF)
      && $stable(lane.rate) |-> gap_r == 4'h1)
    else $error("half rate bit spacing wrong");
  c_reduced_bit: cover property (@(posedge hclk) disable iff (!hresetn)
    taken_r && red_r);
  c_inverted_bit: cover property (@(posedge hclk) disable iff (!hresetn)
    taken_r && lane.invert && pos_r);

endmodule

// ==== rtl/stc_tx_config.sv ====
// Transmit lane configuration register with an AHB-Lite slave port.
//
// Contract
// R1: Bits 31 to 17 read zero, ignore writes.
// R2: Software keeps the fixed-phase enable at one.
// R3: Bits 15 to 12 hold the de-emphasis code.
// R4: De-emphasis lowers amplitude of non-transition bits.
// R5: Bits 11 to 9 hold the swing code.
// R6: Bit 8 raises the output common mode.
// R7: Software raises common mode above 750 mV.
// R8: Bit 7 swaps the transmit pair polarity.
// R9: Bits 6 to 5 divide the line rate.
// R10: Software writes zero to the width field.
// R11: Software writes zero to bit 1.
// R12: Bit 0 enables transmitter, resets to off.
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`include "stc_cfg.svh"

module stc_tx_config
  import stc_pkg::*;
(
  input  wire  logic        hclk,
  input  wire  logic        hresetn,
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output logic              hreadyout,
  output logic [31:0]       hrdata,
  output logic              hresp,
  input  wire  logic        tx_serial_data,
  output logic              fixed_phase_clock_enable,
  output logic [3:0]        deemphasis_level,
  output logic [2:0]        output_swing,
  output logic              common_mode_raise,
  output logic              pair_polarity_invert,
  output logic [1:0]        line_rate_select,
  output logic [2:0]        parallel_path_width,
  output logic              transmitter_enable,
  output logic              tx_out_positive,
  output logic              tx_out_negative,
  output logic              tx_amplitude_reduced,
  output logic              tx_bit_taken
);

  logic [31:0]          cfg_r;
  logic [31:0]          cfg_nxt;
  logic                 dp_wr_r;
  logic                 dp_wr_nxt;
  logic [`STC_DEC_MSB:0] dp_addr_r;
  logic [`STC_DEC_MSB:0] dp_addr_nxt;
  logic [31:0]          rdata_r;
  logic [31:0]          rdata_nxt;
  logic                 ready_r;
  logic                 take;
  logic [31:0]          status;

  stc_lane_if lane_bus ();

  // ****************************************************************
  // Bus address phase
  // ****************************************************************

  // Only whole-word transfers are acted on; other sizes still complete
  // with OKAY but store nothing, and a read leaves hrdata at its last value.
  assign take = hsel && hready && htrans[1] && (hsize == `STC_HSIZE_WORD);

  // The slave never inserts wait states, so a write is applied in the
  // single data phase that follows its address phase.
  always_comb begin
    dp_wr_nxt   = take && hwrite;
    dp_addr_nxt = take ? haddr[`STC_DEC_MSB:0] : dp_addr_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= '0;
      ready_r   <= 1'b0;
    end else begin
      dp_wr_r   <= dp_wr_nxt;
      dp_addr_r <= dp_addr_nxt;
      ready_r   <= 1'b1;
    end
  end

  // ****************************************************************
  // Configuration register
  // ****************************************************************

  // Writes touch only bits 16 down to 0; the upper bits stay zero.
  always_comb begin
    cfg_nxt = cfg_r;
    if (dp_wr_r && (dp_addr_r == `STC_CFG_OFFSET)) begin
      cfg_nxt = (cfg_r & ~`STC_CFG_WMASK) | (hwdata & `STC_CFG_WMASK); // R1
    end
  end

  // Reset leaves the transmitter off until software turns it on.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= `STC_CFG_RESET; // R12
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************

  // Status shows the lane's own activity, taken from its flip-flops.
  always_comb begin
    status                    = 32'h0000_0000;
    status[`STC_ST_ACTIVE]    = lane_bus.taken;
    status[`STC_ST_REDUCED]   = lane_bus.reduced;
    status[`STC_ST_POS]       = lane_bus.pos;
  end

  // Read data is registered at the end of the address phase.  The
  // forwarded next value keeps a read right behind a write coherent.
  always_comb begin
    rdata_nxt = rdata_r;
    if (take && !hwrite) begin
      unique case (haddr[`STC_DEC_MSB:0])
        `STC_CFG_OFFSET:  rdata_nxt = cfg_nxt & `STC_CFG_WMASK; // R1
        `STC_STAT_OFFSET: rdata_nxt = status;
        default:          rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Every field output is a slice of the register itself.
  assign hreadyout                = ready_r;
  assign hrdata                   = rdata_r;
  assign hresp                    = 1'b0;
  assign fixed_phase_clock_enable = cfg_r[`STC_FTP_BIT];
  assign deemphasis_level = cfg_r[`STC_DE_MSB:`STC_DE_LSB]; // R3
  assign output_swing = cfg_r[`STC_SWING_MSB:`STC_SWING_LSB]; // R5
  assign common_mode_raise = cfg_r[`STC_CM_BIT]; // R6
  assign pair_polarity_invert     = cfg_r[`STC_INV_BIT];
  assign line_rate_select         = cfg_r[`STC_RATE_MSB:`STC_RATE_LSB];
  assign parallel_path_width      = cfg_r[`STC_WIDTH_MSB:`STC_WIDTH_LSB];
  assign transmitter_enable = cfg_r[`STC_EN_BIT]; // R12
  assign tx_out_positive          = lane_bus.pos;
  assign tx_out_negative          = lane_bus.neg;
  assign tx_amplitude_reduced     = lane_bus.reduced;
  assign tx_bit_taken             = lane_bus.taken;

  // Settings that steer the output stage.
  assign lane_bus.deemph = cfg_r[`STC_DE_MSB:`STC_DE_LSB];
  assign lane_bus.invert = cfg_r[`STC_INV_BIT];
  assign lane_bus.rate   = stc_rate_type'(
                             cfg_r[`STC_RATE_MSB:`STC_RATE_LSB]);
  assign lane_bus.enable = cfg_r[`STC_EN_BIT];

  stc_lane_drive u_lane (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .tx_serial_data (tx_serial_data),
    .lane           (lane_bus)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************

  logic cfg_wr;
  assign cfg_wr = dp_wr_r && (dp_addr_r == `STC_CFG_OFFSET);

  // Reserved upper bits must never appear, neither stored nor returned.
  a_upper_bits_zero: assert property ( // R1
    @(posedge hclk) disable iff (!hresetn)
    (hrdata[31:17] == 15'h0) && (cfg_r[31:17] == 15'h0))
    else $error("bits 31 to 17 not zero");
  a_deemph_stored: assert property ( // R3
    @(posedge hclk) disable iff (!hresetn)
    cfg_wr |=> deemphasis_level == $past(hwdata[15:12]))
    else $error("de-emphasis code not stored");
  a_swing_stored: assert property ( // R5
    @(posedge hclk) disable iff (!hresetn)
    cfg_wr |=> output_swing == $past(hwdata[11:9]))
    else $error("swing code not stored");
  a_cm_stored: assert property ( // R6
    @(posedge hclk) disable iff (!hresetn)
    cfg_wr |=> common_mode_raise == $past(hwdata[8]))
    else $error("common mode bit not stored");
  a_enable_held: assert property ( // R12
    @(posedge hclk) disable iff (!hresetn)
    !cfg_wr |=> $stable(transmitter_enable))
    else $error("enable moved without a write");
  a_idle_when_off: assert property ( // R12
    @(posedge hclk) disable iff (!hresetn)
    !transmitter_enable ##1 !transmitter_enable
      |-> !tx_out_positive && !tx_out_negative && !tx_bit_taken)
    else $error("pair driven while disabled");
  a_readback: assert property ( // R1
    @(posedge hclk) disable iff (!hresetn)
    take && !hwrite && (haddr[`STC_DEC_MSB:0] == `STC_CFG_OFFSET)
      |=> hrdata == cfg_r)
    else $error("read-back differs from register");
  c_write_read: cover property (@(posedge hclk) disable iff (!hresetn)
    cfg_wr ##1 (take && !hwrite));
  c_lane_on: cover property (@(posedge hclk) disable iff (!hresetn)
    transmitter_enable && tx_bit_taken);
  c_quarter_rate: cover property (@(posedge hclk) disable iff (!hresetn)
    tx_bit_taken && (line_rate_select == 2'h2));

endmodule

// ==== verification/serdes_tx_config_regs_tb.sv ====
// Self-checking testbench for the transmit lane configuration register.
`include "stc_cfg.svh"

module serdes_tx_config_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        tx_serial_data;
  logic        ftp_en;
  logic [3:0]  deemph;
  logic [2:0]  swing;
  logic        cm_raise;
  logic        invert;
  logic [1:0]  rate;
  logic [2:0]  width;
  logic        tx_en;
  logic        pos;
  logic        neg;
  logic        reduced;
  logic        taken;
  logic        toggle_data;
  logic        data_level;
  int          fail_count;
  int          num_checks;
  int          cycles;
  logic [31:0] rd;
  logic [2:0]  xfer_size;

  // The single slave's ready is the bus ready.
  assign hready = hreadyout;

  stc_tx_config i_dut (
    .hclk                     (hclk),
    .hresetn                  (hresetn),
    .hsel                     (hsel),
    .haddr                    (haddr),
    .htrans                   (htrans),
    .hwrite                   (hwrite),
    .hsize                    (hsize),
    .hwdata                   (hwdata),
    .hready                   (hready),
    .hreadyout                (hreadyout),
    .hrdata                   (hrdata),
    .hresp                    (hresp),
    .tx_serial_data           (tx_serial_data),
    .fixed_phase_clock_enable (ftp_en),
    .deemphasis_level         (deemph),
    .output_swing             (swing),
    .common_mode_raise        (cm_raise),
    .pair_polarity_invert     (invert),
    .line_rate_select         (rate),
    .parallel_path_width      (width),
    .transmitter_enable       (tx_en),
    .tx_out_positive          (pos),
    .tx_out_negative          (neg),
    .tx_amplitude_reduced     (reduced),
    .tx_bit_taken             (taken)
  );

  // ****************************************************************
  // Clock, serial data source and hang guard
  // ****************************************************************
  always #5 hclk = ~hclk;

  // Serial data either holds a level or toggles every cycle.
  always @(posedge hclk) begin
    tx_serial_data <= toggle_data ? ~tx_serial_data : data_level;
  end

  // A run far longer than the scenarios need means a hung handshake.
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits for hready sampled high at a rising edge and takes read data
  // at that edge; only the cycle limit ends a wait that never ends.
  task automatic wait_rdy(output logic [31:0] d);
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
    end
    d = hrdata;
  endtask

  task automatic ahb_xfer(input logic wr, input logic [31:0] a,
                          input logic [31:0] wd, output logic [31:0] d);
    logic [31:0] tmp;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= xfer_size;
    wait_rdy(tmp);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_rdy(d);
  endtask

  task automatic wr_cfg(input logic [31:0] v);
    logic [31:0] unused;
    ahb_xfer(1'b1, 32'(`STC_CFG_OFFSET), v, unused);
  endtask

  task automatic settle();
    repeat (6) @(negedge hclk);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset state: register clear, transmitter off, pair resting low.
  task automatic t_reset();
    ahb_xfer(1'b0, 32'(`STC_CFG_OFFSET), 32'h0, rd);
    chk("cfg reset", 32'h0000_0000, rd);
    chk("tx_en reset", 32'h0, {31'h0, tx_en});
    chk("pair reset", 32'h0, {30'h0, pos, neg});
  endtask

  // All ones: only bits 16..0 stick; each field reaches its output.
  task automatic t_all_ones();
    // Width field and bit 1 stay zero, as software must keep them.
    wr_cfg(32'hffff_ffe1);
    ahb_xfer(1'b0, 32'(`STC_CFG_OFFSET), 32'h0, rd);
    chk("cfg readback", 32'h0001_ffe1, rd);
    chk("ftp_en", 32'h1, {31'h0, ftp_en});
    chk("width", 32'h0, {29'h0, width});
    chk("deemph", 32'hf, {28'h0, deemph});
    chk("swing", 32'h7, {29'h0, swing});
    chk("cm_raise", 32'h1, {31'h0, cm_raise});
    chk("invert", 32'h1, {31'h0, invert});
    chk("rate", 32'h3, {30'h0, rate});
    chk("tx_en", 32'h1, {31'h0, tx_en});
  endtask

  // Unmapped writes are dropped and unmapped reads return zero.
  task automatic t_unmapped();
    logic [31:0] unused;
    ahb_xfer(1'b1, 32'h0000_0008, 32'hffff_ffff, unused);
    ahb_xfer(1'b0, 32'h0000_0008, 32'h0, rd);
    chk("unmapped read", 32'h0, rd);
    chk("hresp okay", 32'h0, {31'h0, hresp});
    // A halfword write is completed but must not touch the register.
    xfer_size = 3'h1;
    wr_cfg(32'h0000_0000);
    xfer_size = `STC_HSIZE_WORD;
    ahb_xfer(1'b0, 32'(`STC_CFG_OFFSET), 32'h0, rd);
    chk("cfg kept", 32'h0001_ffe1, rd);
  endtask

  // The full, half and quarter rate codes space the bit strobes by 1, 2 or 4 cycles.
  task automatic t_rates();
    int cnt;
    for (int c = 0; c < 3; c++) begin
      wr_cfg(32'h0001_0001 | (32'(c) << 5));
      settle();
      cnt = 0;
      repeat (16) begin
        @(negedge hclk);
        if (taken === 1'b1) cnt++;
      end
      chk("strobes per 16", 32'(16 >> c), 32'(cnt));
    end
  endtask

  // Steady data is reduced, toggling data is not, code zero never is.
  task automatic t_deemph();
    data_level  <= 1'b1;
    toggle_data <= 1'b0;
    // Large swing paired with raised common mode, as recommended.
    wr_cfg(32'h0001_5b01);
    settle();
    chk("swing code", 32'h5, {29'h0, swing});
    chk("pair normal", 32'h2, {30'h0, pos, neg});
    chk("steady reduced", 32'h1, {31'h0, reduced});
    // Status: a bit taken every cycle, reduced, positive leg high.
    ahb_xfer(1'b0, 32'(`STC_STAT_OFFSET), 32'h0, rd);
    chk("status", 32'h7, rd);
    toggle_data <= 1'b1;
    settle();
    chk("toggle full", 32'h0, {31'h0, reduced});
    toggle_data <= 1'b0;
    wr_cfg(32'h0001_0b01);
    settle();
    chk("code zero", 32'h0, {31'h0, reduced});
  endtask

  // Inversion swaps the legs; disable parks both low with no strobes.
  task automatic t_invert_disable();
    int cnt;
    wr_cfg(32'h0001_0b81);
    settle();
    chk("pair inverted", 32'h1, {30'h0, pos, neg});
    wr_cfg(32'h0001_0000);
    settle();
    cnt = 0;
    repeat (8) begin
      @(negedge hclk);
      if (taken === 1'b1) cnt++;
    end
    chk("disabled strobes", 32'h0, 32'(cnt));
    chk("disabled pair", 32'h0, {30'h0, pos, neg});
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    hclk           = 1'b0;
    hresetn        = 1'b0;
    hsel           = 1'b0;
    haddr          = 32'h0;
    htrans         = 2'b00;
    hwrite         = 1'b0;
    hsize          = `STC_HSIZE_WORD;
    xfer_size      = `STC_HSIZE_WORD;
    hwdata         = 32'h0;
    tx_serial_data = 1'b0;
    toggle_data    = 1'b0;
    data_level     = 1'b0;
    fail_count     = 0;
    num_checks     = 0;
    cycles         = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_all_ones();
    t_unmapped();
    t_rates();
    t_deemph();
    t_invert_disable();
    wrap_up();
  end
endmodule
